/* bpsc_consts.svh */
// Constants of the backup power state controller: offsets, codes, timings.
// Assumes a 125 MHz clock; included by the package and the controller.
`ifndef BPSC_CONSTS_SVH
`define BPSC_CONSTS_SVH
`define BPSC_ADDR_STATUS     8'h00
`define BPSC_ADDR_CTRL       8'h06
`define BPSC_ADDR_FAULT      8'h07
`define BPSC_CTRL_BLOCKING_SWITCH_BIT   2
`define BPSC_STATE_LSB       0
`define BPSC_CTRL_RESET      8'h00
`define BPSC_CLK_NS          8
`define BPSC_SS_TIME_NS      1000000
`define BPSC_SS_CYCLES       ((`BPSC_SS_TIME_NS + `BPSC_CLK_NS - 1) / `BPSC_CLK_NS)
`endif

/* bpsc_pkg.sv */
// Types of the backup power state controller.
// Assumes bpsc_consts.svh sits in the same folder.
`include "bpsc_consts.svh"
package bpsc_pkg;
    typedef enum logic [2:0] {
        BPSC_ST_POR      = 3'h0,
        BPSC_ST_SOFT     = 3'h1,
        BPSC_ST_NORMAL   = 3'h2,
        BPSC_ST_HEALTH   = 3'h3,
        BPSC_ST_BACKUP   = 3'h4,
        BPSC_ST_INHIBIT  = 3'h5,
        BPSC_ST_SHUTDOWN = 3'h6
    } bpsc_state_e;
    // Comparator decisions from the analog front end.
    typedef struct packed {
        logic master_en;
        logic input_ok;
        logic vin_vout_ok;
        logic input_fault;
        logic vout_vb_ok;
        logic temp_warn;
        logic temp_hot;
        logic temp_shutdown;
        logic overcurrent;
        logic ref_ok;
        logic boot_ok;
        logic comp_ok;
        logic storage_full;
        logic storage_above_vin;
        logic storage_low;
        logic health_req;
        logic health_done;
        logic health_fail;
    } bpsc_sense_s;
    typedef struct packed {
        logic input_switch;
        logic boost;
        logic buck;
        logic blocking_switch;
        logic charge_cc;
        logic reference;
    } bpsc_enables_s;
    typedef struct packed {
        logic power_loss_flag;
        logic output_good;
        logic storage_good;
        logic fault_alert;
    } bpsc_flags_s;
    typedef struct packed {
        bpsc_state_e   state;
        logic [19:0]   timer;
        logic [7:0]    ctrl;
        logic          fault_latch;
        logic          alert_pend;
        bpsc_enables_s en;
        bpsc_flags_s   flg;
        logic [7:0]    rdata;
        logic          rvalid;
        logic [1:0]    sync_a_stor;
        logic [1:0]    sync_b_stor;
    } bpsc_reg_s;
endpackage

/* bpsc_ctrl.sv */
// Backup power state controller with its small register port.
// Assumes sense inputs come from asynchronous comparators and pins.
//
// Overview of operation
// - Backup-inhibit keeps the output powered and never enters backup.
// - Storage-good is held low throughout backup-inhibit.
// - After soft-start, pass through normal straight into backup-inhibit.
// - In inhibit the blocking switch is on by pin or control bit.
// - Charge first at constant current to input level, then boost.
// - Storage full: leave inhibit for normal, storage-good rises.
// - Failed readiness check in normal: alert low, then backup-inhibit.
// - Over the shutdown temperature, enter shutdown with everything off.
// - The register port does not answer in shutdown.
// - Leave shutdown for soft-start once cool and no overcurrent.
// - The present state code is readable in the status register.
// - Each state drives a base set of enables; pin, control bit, heat and health check adjust it.
// - Normal: switches on, boost recharges, all status outputs high.
// - Master enable low in normal: enter backup, statuses low, then off.
// - Storage-path pin low: boost, buck off, blocking switch off outside inhibit; alert low.
// - Health check holds boost off; failure drops storage-good and alert.
// - Warm band keeps running but raises the thermal alert.
// - Hot band stops boost, storage-good follows storage, alert low.
// - Alert stays low until status is read, and while fault persists.
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`include "bpsc_consts.svh"
module bpsc_ctrl
    import bpsc_pkg::*;
#(
    parameter int SS_CYCLES = `BPSC_SS_CYCLES
) (
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire bpsc_sense_s   sense_in,
    input  wire logic          storage_path_enable_pin,
    input  wire logic [7:0]    reg_addr,
    input  wire logic [7:0]    reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic [7:0]         reg_rdata,
    output bpsc_enables_s      enables_out,
    output logic               power_loss_flag_out,
    output logic               output_good_out,
    output logic               storage_good_out,
    output logic               fault_alert_out,
    output logic               fault_alert_oe
);
    bpsc_reg_s   r_q;
    bpsc_reg_s   r_d;
    bpsc_sense_s s1_q;
    bpsc_sense_s s_q;
    logic        pin1_q;
    logic        pin_q;

    // Two stages before anything reads the comparators.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s1_q   <= '0;
            s_q    <= '0;
            pin1_q <= 1'b0;
            pin_q  <= 1'b0;
        end else begin
            s1_q   <= sense_in;
            s_q    <= s1_q;
            pin1_q <= storage_path_enable_pin;
            pin_q  <= pin1_q;
        end
    end

    function automatic bpsc_enables_s state_enables(input bpsc_state_e st);
        bpsc_enables_s e;
        e = '0;
        unique case (st)
            BPSC_ST_POR, BPSC_ST_SHUTDOWN: e = '0;
            BPSC_ST_SOFT: begin
                e.input_switch = 1'b1;
                e.reference    = 1'b1;
            end
            BPSC_ST_NORMAL, BPSC_ST_HEALTH: begin
                e.input_switch    = 1'b1;
                e.boost           = 1'b1;
                e.blocking_switch = 1'b1;
                e.reference       = 1'b1;
            end
            BPSC_ST_BACKUP: begin
                e.buck            = 1'b1;
                e.blocking_switch = 1'b1;
                e.reference       = 1'b1;
            end
            BPSC_ST_INHIBIT: begin
                e.input_switch    = 1'b1;
                e.blocking_switch = 1'b1;
                e.reference       = 1'b1;
            end
            default: e = '0;
        endcase
        return e;
    endfunction

    logic ready_ok;
    logic fault_now;
    logic blocking_switch_req;
    logic hot_any;
    logic pass_normal;

    always_comb begin
        r_d       = r_q;
        // Readiness checks that make backup possible.
        ready_ok  = s_q.vout_vb_ok && !s_q.temp_hot && s_q.ref_ok &&
                    s_q.boot_ok && s_q.comp_ok;
        blocking_switch_req  = pin_q || r_q.ctrl[`BPSC_CTRL_BLOCKING_SWITCH_BIT];
        hot_any   = s_q.temp_warn || s_q.temp_hot;
        fault_now = hot_any || !pin_q || !ready_ok ||
                    r_q.state == BPSC_ST_BACKUP ||
                    (r_q.state == BPSC_ST_HEALTH && s_q.health_fail);
        pass_normal = 1'b0;
        r_d.rvalid = 1'b0;
        r_d.rdata  = '0;
        r_d.timer  = '0;
        r_d.alert_pend = 1'b0;

        // The register port is silent during shutdown.
        if (r_q.state != BPSC_ST_SHUTDOWN) begin
            if (reg_wr && reg_addr == `BPSC_ADDR_CTRL) begin
                r_d.ctrl = reg_wdata;
            end
            if (reg_rd) begin
                unique case (reg_addr)
                    `BPSC_ADDR_STATUS: begin
                        r_d.rdata = {5'h00, r_q.state};
                        r_d.fault_latch = 1'b0;
                    end
                    `BPSC_ADDR_CTRL:  r_d.rdata = r_q.ctrl;
                    `BPSC_ADDR_FAULT: r_d.rdata = {7'h00, r_q.fault_latch};
                    default:          r_d.rdata = '0;
                endcase
            end
        end
        // A persisting fault sets again and wins over the read.
        if (fault_now && r_q.state != BPSC_ST_POR &&
            r_q.state != BPSC_ST_SOFT) begin
            r_d.fault_latch = 1'b1;
        end

        if (s_q.temp_shutdown) begin
            r_d.state = BPSC_ST_SHUTDOWN;
        end else begin
            unique case (r_q.state)
                BPSC_ST_POR: begin
                    if (s_q.master_en && s_q.input_ok) begin
                        r_d.state = BPSC_ST_SOFT;
                    end
                end
                BPSC_ST_SOFT: begin
                    r_d.timer = r_q.timer + 20'h00001;
                    if (!s_q.master_en || !s_q.input_ok) begin
                        r_d.state = BPSC_ST_POR;
                    end else if (s_q.vin_vout_ok &&
                                 r_q.timer >= 20'(SS_CYCLES - 1)) begin
                        r_d.state = BPSC_ST_NORMAL;
                        r_d.alert_pend = 1'b1;
                    end
                end
                BPSC_ST_NORMAL, BPSC_ST_HEALTH: begin
                    if (!s_q.master_en || s_q.input_fault) begin
                        r_d.state = BPSC_ST_BACKUP;
                    end else if (r_q.alert_pend) begin
                        // Transit after soft-start goes on to inhibit.
                        r_d.state = BPSC_ST_INHIBIT;
                    end else if (!ready_ok) begin
                        // Move only once the alert is out, so the host
                        // hears of the failure ahead of the change.
                        if (!r_q.flg.fault_alert) begin
                            r_d.state = BPSC_ST_INHIBIT;
                        end
                    end else if (r_q.state == BPSC_ST_HEALTH) begin
                        if (s_q.health_fail) begin
                            r_d.state = BPSC_ST_INHIBIT;
                        end else if (s_q.health_done) begin
                            r_d.state = BPSC_ST_NORMAL;
                        end
                    end else if (s_q.health_req) begin
                        r_d.state = BPSC_ST_HEALTH;
                    end
                end
                BPSC_ST_BACKUP: begin
                    if (s_q.storage_low || !s_q.master_en) begin
                        if (s_q.storage_low) begin
                            r_d.state = BPSC_ST_POR;
                        end
                    end
                end
                BPSC_ST_INHIBIT: begin
                    // No way to backup from here.
                    if (!s_q.master_en) begin
                        r_d.state = BPSC_ST_POR;
                    end else if (s_q.storage_full && ready_ok && pin_q) begin
                        pass_normal = 1'b1;
                        r_d.state = BPSC_ST_NORMAL;
                    end
                end
                BPSC_ST_SHUTDOWN: begin
                    if (!s_q.overcurrent) begin
                        r_d.state = BPSC_ST_SOFT;
                    end
                end
                default: r_d.state = BPSC_ST_POR;
            endcase
        end

        r_d.en = state_enables(r_d.state);
        if (r_d.state == BPSC_ST_INHIBIT) begin
            r_d.en.blocking_switch = blocking_switch_req;
            // Constant current up to input level, then boost.
            r_d.en.charge_cc = blocking_switch_req && !s_q.storage_above_vin;
            r_d.en.boost = blocking_switch_req && s_q.storage_above_vin &&
                           !s_q.temp_hot;
        end
        if (r_d.state == BPSC_ST_HEALTH || s_q.temp_hot) begin
            r_d.en.boost = 1'b0;
        end
        if (!pin_q) begin
            // In inhibit the control bit alone may still close the switch,
            // so the host can charge storage before raising the pin.
            if (r_d.state != BPSC_ST_INHIBIT) begin
                r_d.en.blocking_switch = 1'b0;
                r_d.en.charge_cc       = 1'b0;
            end
            r_d.en.boost           = 1'b0;
            r_d.en.buck            = 1'b0;
        end

        unique case (r_d.state)
            BPSC_ST_NORMAL, BPSC_ST_HEALTH, BPSC_ST_INHIBIT: begin
                r_d.flg.power_loss_flag = 1'b1;
                r_d.flg.output_good     = 1'b1;
            end
            default: begin
                r_d.flg.power_loss_flag = 1'b0;
                r_d.flg.output_good     = 1'b0;
            end
        endcase
        if (r_d.state == BPSC_ST_INHIBIT) begin
            r_d.flg.storage_good = 1'b0;
        end else if (r_d.state == BPSC_ST_HEALTH && s_q.health_fail) begin
            r_d.flg.storage_good = 1'b0;
        end else if (!pin_q || s_q.temp_hot) begin
            r_d.flg.storage_good = s_q.storage_full;
        end else begin
            r_d.flg.storage_good = r_d.state == BPSC_ST_NORMAL ||
                                   r_d.state == BPSC_ST_HEALTH ||
                                   pass_normal;
        end
        // Alert low on fault, warm band, or unread latched fault.
        r_d.flg.fault_alert = !(r_d.fault_latch || fault_now);
        if (r_d.state == BPSC_ST_POR || r_d.state == BPSC_ST_SHUTDOWN) begin
            r_d.flg.fault_alert = 1'b0;
        end
        r_d.rvalid = reg_rd;
        r_d.sync_a_stor = '0;
        r_d.sync_b_stor = '0;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            r_q       <= '0;
            r_q.state <= BPSC_ST_POR;
            r_q.ctrl  <= `BPSC_CTRL_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    assign reg_rdata           = r_q.rdata;
    assign enables_out         = r_q.en;
    assign power_loss_flag_out = r_q.flg.power_loss_flag;
    assign output_good_out     = r_q.flg.output_good;
    assign storage_good_out    = r_q.flg.storage_good;
    assign fault_alert_out     = 1'b0;
    assign fault_alert_oe      = !r_q.flg.fault_alert;

    AST_INHIBIT_NO_BACKUP: assert property (@(posedge clk) disable iff (!rst_b)
        r_q.state == BPSC_ST_INHIBIT && !s_q.temp_shutdown |=>
        r_q.state != BPSC_ST_BACKUP) else $error("Backup from inhibit");
    AST_INHIBIT_STR_LOW: assert property (@(posedge clk) disable iff (!rst_b)
        r_q.state == BPSC_ST_INHIBIT |-> !storage_good_out)
        else $error("Storage good high in inhibit");
    AST_SOFT_TO_INHIBIT: assert property (@(posedge clk) disable iff (!rst_b)
        $past(r_q.state) == BPSC_ST_SOFT && r_q.state == BPSC_ST_NORMAL &&
        s_q.master_en && !s_q.input_fault && !s_q.temp_shutdown |=>
        r_q.state == BPSC_ST_INHIBIT) else $error("No pass to inhibit");
    AST_BLOCKING_SWITCH_IN_INHIBIT: assert property (
        @(posedge clk) disable iff (!rst_b)
        r_d.state == BPSC_ST_INHIBIT && blocking_switch_req |=> enables_out.blocking_switch)
        else $error("Blocking switch off");
    AST_CC_THEN_BOOST: assert property (@(posedge clk) disable iff (!rst_b)
        !(enables_out.charge_cc && enables_out.boost))
        else $error("Both charge phases");
    AST_SHUTDOWN_OFF: assert property (@(posedge clk) disable iff (!rst_b)
        $past(s_q.temp_shutdown) |-> r_q.state == BPSC_ST_SHUTDOWN &&
        enables_out == '0) else $error("Shutdown not off");
    AST_SHUTDOWN_SILENT: assert property (@(posedge clk) disable iff (!rst_b)
        r_q.state == BPSC_ST_SHUTDOWN && reg_rd |=> reg_rdata == 8'h00)
        else $error("Port answered in shutdown");
    AST_STATE_READ: assert property (@(posedge clk) disable iff (!rst_b)
        reg_rd && reg_addr == `BPSC_ADDR_STATUS &&
        r_q.state != BPSC_ST_SHUTDOWN |=> reg_rdata[2:0] == $past(r_q.state))
        else $error("State code wrong");
    AST_PIN_LOW_OFF: assert property (
        @(posedge clk) disable iff (!rst_b)
        !pin_q |=> !enables_out.boost && !enables_out.buck &&
        fault_alert_oe && (!enables_out.blocking_switch ||
        r_q.state == BPSC_ST_INHIBIT && $past(r_q.ctrl[`BPSC_CTRL_BLOCKING_SWITCH_BIT])))
        else $error("Pin low ignored");
    AST_HOT_NO_BOOST: assert property (@(posedge clk) disable iff (!rst_b)
        s_q.temp_hot |=> !enables_out.boost) else $error("Boost hot");
    AST_ALERT_THEN_INHIBIT: assert property (
        @(posedge clk) disable iff (!rst_b)
        r_q.state == BPSC_ST_NORMAL && !r_q.alert_pend &&
        r_d.state == BPSC_ST_INHIBIT |-> !r_q.flg.fault_alert)
        else $error("Inhibit before alert");
    AST_STR_RISES_ON_EXIT: assert property (
        @(posedge clk) disable iff (!rst_b)
        r_q.state == BPSC_ST_INHIBIT ##1 r_q.state == BPSC_ST_NORMAL
        |-> storage_good_out)
        else $error("Storage good low after charge");
    AST_NORMAL_STATUS: assert property (
        @(posedge clk) disable iff (!rst_b)
        r_q.state == BPSC_ST_NORMAL |-> power_loss_flag_out &&
        output_good_out && enables_out.input_switch)
        else $error("Normal status wrong");
    AST_BACKUP_STATUS: assert property (
        @(posedge clk) disable iff (!rst_b)
        r_q.state == BPSC_ST_BACKUP |-> !power_loss_flag_out &&
        !output_good_out && !enables_out.input_switch && !enables_out.boost)
        else $error("Backup status wrong");
    AST_SOFT_ENABLES: assert property (
        @(posedge clk) disable iff (!rst_b)
        r_q.state == BPSC_ST_SOFT |-> enables_out == 6'h21)
        else $error("Soft-start enables wrong");
    AST_OC_HOLDS_SHUTDOWN: assert property (
        @(posedge clk) disable iff (!rst_b)
        r_q.state == BPSC_ST_SHUTDOWN && s_q.overcurrent |=>
        r_q.state == BPSC_ST_SHUTDOWN)
        else $error("Shutdown left with overcurrent");
    AST_HEALTH_NO_BOOST: assert property (
        @(posedge clk) disable iff (!rst_b)
        r_q.state == BPSC_ST_HEALTH |-> !enables_out.boost)
        else $error("Boost on in health check");
    AST_WARN_ALERT: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_q.temp_warn |=> fault_alert_oe)
        else $error("No thermal alert");
    AST_LATCH_HOLDS: assert property (
        @(posedge clk) disable iff (!rst_b)
        r_q.fault_latch && !(reg_rd && reg_addr == `BPSC_ADDR_STATUS) |=>
        r_q.fault_latch)
        else $error("Fault latch lost without read");
endmodule

/* bpsc_host.sv */
// Host processor model: register port master and storage path pin.
// Assumes the controller takes its port requests on the rising clk edge.
`timescale 1ns/1ns
module bpsc_host (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic            storage_path_enable_pin
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        storage_path_enable_pin = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // A status read is what lets a latched alert go away.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask
    // The pin is a plain level; the controller synchronises it.
    task automatic set_pin(input logic v);
        @(posedge clk);
        storage_path_enable_pin <= v;
    endtask
endmodule

/* tb.sv */
// Testbench of the backup power state controller.
// Assumes bpsc_pkg and bpsc_host are compiled first; one 125 MHz clock.
`timescale 1ns/1ns
`include "bpsc_consts.svh"
module tb;
    import bpsc_pkg::*;
    logic          clk = 1'b0;
    logic          rst_b = 1'b0;
    bpsc_sense_s   sense = '0;
    logic          pin;
    logic [7:0]    reg_addr;
    logic [7:0]    reg_wdata;
    logic          reg_wr;
    logic          reg_rd;
    logic [7:0]    reg_rdata;
    bpsc_enables_s enables_out;
    logic          pl;
    logic          og;
    logic          sg;
    logic          fa;
    logic          fa_oe;
    logic [7:0]    v;
    int            error_cnt = 0;
    int            n_compared = 0;
    always #4 clk = ~clk;
    bpsc_ctrl #(.SS_CYCLES(4)) uut (.clk(clk), .rst_b(rst_b),
        .sense_in(sense), .storage_path_enable_pin(pin),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .enables_out(enables_out),
        .power_loss_flag_out(pl), .output_good_out(og),
        .storage_good_out(sg), .fault_alert_out(fa), .fault_alert_oe(fa_oe));
    bpsc_host host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .storage_path_enable_pin(pin));
    task automatic give_verdict();
        if (error_cnt == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    function automatic logic [7:0] en(input logic [5:0] m);
        return {2'h0, enables_out & m};
    endfunction
    function automatic logic [7:0] fl();
        return {4'h0, pl, og, sg, fa_oe};
    endfunction
    // Sense changes need two sync stages plus one update cycle.
    task automatic settle();
        repeat (4) @(posedge clk);
    endtask
    task automatic wait_st(input logic [2:0] s);
        for (int i = 0; i < 300; i++) begin
            host.rd(`BPSC_ADDR_STATUS, v);
            if (v === {5'h0, s})
                return;
        end
        chk("state wait", {5'h0, s}, v);
        give_verdict();
    endtask
    task automatic t_start();
        chk("enables reset", 8'h00, en(6'h3f));
        chk("alert level", 8'h00, {7'h0, fa});
        host.rd(`BPSC_ADDR_STATUS, v);
        chk("state por", 8'h00, v);
        @(posedge clk);
        sense.master_en <= 1'b1;
        sense.input_ok <= 1'b1;
        sense.vin_vout_ok <= 1'b1;
        sense.vout_vb_ok <= 1'b1;
        sense.ref_ok <= 1'b1;
        sense.boot_ok <= 1'b1;
        sense.comp_ok <= 1'b1;
        wait_st(3'h5);
        chk("sg inhibit", 8'h00, {7'h0, sg});
        chk("en inhibit", 8'h21, en(6'h3d));
        host.wr(`BPSC_ADDR_CTRL, 8'h04);
        settle();
        chk("bsw by bit", 8'h04, en(6'h04));
        host.rd(`BPSC_ADDR_CTRL, v);
        chk("ctrl read", 8'h04, v);
        host.wr(`BPSC_ADDR_CTRL, 8'h00);
        host.set_pin(1'b1);
        settle();
        chk("bsw by pin", 8'h04, en(6'h04));
        host.rd(8'h3c, v);
        chk("unmapped", 8'h00, v);
    endtask
    task automatic t_inhibit_hold();
        @(posedge clk);
        sense.input_fault <= 1'b1;
        repeat (3) settle();
        host.rd(`BPSC_ADDR_STATUS, v);
        chk("no backup", 8'h05, v);
        chk("og held", 8'h01, {7'h0, og});
        @(posedge clk);
        sense.input_fault <= 1'b0;
        settle();
    endtask
    task automatic t_charge();
        chk("cc phase", 8'h02, en(6'h12));
        @(posedge clk);
        sense.storage_above_vin <= 1'b1;
        settle();
        chk("boost phase", 8'h10, en(6'h12));
        @(posedge clk);
        sense.storage_full <= 1'b1;
        wait_st(3'h2);
        host.rd(`BPSC_ADDR_STATUS, v);
        chk("flags normal", 8'h0e, fl());
        chk("en normal", 8'h25, en(6'h2d));
    endtask
    task automatic t_ready_fail();
        @(posedge clk);
        sense.vout_vb_ok <= 1'b0;
        settle();
        chk("alert first", 8'h01, {7'h0, fa_oe});
        wait_st(3'h5);
        settle();
        chk("alert persists", 8'h01, {7'h0, fa_oe});
        @(posedge clk);
        sense.vout_vb_ok <= 1'b1;
        wait_st(3'h2);
        settle();
        host.rd(`BPSC_ADDR_STATUS, v);
        chk("alert released", 8'h00, {7'h0, fa_oe});
    endtask
    task automatic t_thermal();
        @(posedge clk);
        sense.temp_warn <= 1'b1;
        settle();
        chk("warn alert", 8'h01, {7'h0, fa_oe});
        host.rd(`BPSC_ADDR_STATUS, v);
        chk("warn state", 8'h02, v);
        sense.temp_warn <= 1'b0;
        sense.temp_hot <= 1'b1;
        settle();
        chk("hot enables", 8'h24, en(6'h34));
        chk("hot alert", 8'h01, {7'h0, fa_oe});
        @(posedge clk);
        sense.temp_hot <= 1'b0;
        settle();
        host.rd(`BPSC_ADDR_STATUS, v);
        chk("hot cleared", 8'h00, {7'h0, fa_oe});
    endtask
    task automatic t_pin_low();
        host.set_pin(1'b0);
        settle();
        chk("pin low en", 8'h20, en(6'h3c));
        chk("pin low flags", 8'h0d, fl() & 8'h0d);
        host.set_pin(1'b1);
        settle();
        host.rd(`BPSC_ADDR_STATUS, v);
    endtask
    task automatic t_health();
        @(posedge clk);
        sense.health_req <= 1'b1;
        wait_st(3'h3);
        chk("health boost", 8'h00, en(6'h10));
        sense.health_req <= 1'b0;
        sense.health_fail <= 1'b1;
        sense.health_done <= 1'b1;
        settle();
        chk("health fail", 8'h01, fl() & 8'h03);
        sense.health_fail <= 1'b0;
        sense.health_done <= 1'b0;
    endtask
    task automatic t_shutdown();
        @(posedge clk);
        sense.temp_shutdown <= 1'b1;
        sense.overcurrent <= 1'b1;
        settle();
        chk("sd enables", 8'h00, en(6'h3f));
        chk("sd flags", 8'h00, fl() & 8'h0e);
        host.rd(`BPSC_ADDR_STATUS, v);
        chk("sd silent", 8'h00, v);
        host.wr(`BPSC_ADDR_CTRL, 8'h04);
        sense.temp_shutdown <= 1'b0;
        repeat (3) settle();
        chk("oc holds sd", 8'h00, en(6'h3f));
        sense.overcurrent <= 1'b0;
        wait_st(3'h2);
        host.rd(`BPSC_ADDR_CTRL, v);
        chk("sd write lost", 8'h00, v);
    endtask
    task automatic t_backup();
        @(posedge clk);
        sense.master_en <= 1'b0;
        wait_st(3'h4);
        chk("backup en", 8'h0d, en(6'h3d));
        chk("backup flags", 8'h01, fl());
        @(posedge clk);
        sense.storage_low <= 1'b1;
        settle();
        chk("off after", 8'h00, en(6'h3f));
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        t_start();
        t_inhibit_hold();
        t_charge();
        t_ready_fail();
        t_thermal();
        t_pin_low();
        t_health();
        t_shutdown();
        t_backup();
        give_verdict();
    end
endmodule
